//--- design/dsw_two_stage_guard_timer.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RULE1: two programmable stages run in sequence; stage two starts after stage one expires
// RULE2: action code zero disables a stage; it is skipped with no action
// RULE3: reset code at expiry restarts the whole module
// RULE4: delay code is only accepted in stage one; it just extends time
// RULE5: output-only code pulses the alert; reset-plus-output pulses alert and restarts
// RULE6: delay-plus-output pulses the alert at expiry then takes no further action
// RULE7: the alert output on the connector signals a stage expiry
// RULE8: configuration ties the alert output to either stage
// RULE9: an unserviced watchdog takes the configured corrective action
// RULE10: software services before expiry; each service restarts from stage one
// RULE11: each stage counts its own timeout in clock ticks; unknown codes do nothing
module dsw_two_stage_guard_timer #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // configuration
  input wire logic i_enable,
  input wire logic [3:0] i_stage1_code,
  input wire logic [3:0] i_stage2_code,
  input wire logic [CNT_W-1:0] i_stage1_ticks,
  input wire logic [CNT_W-1:0] i_stage2_ticks,
  input wire logic i_alert_sel,
  // software service pulse
  input wire logic i_service,
  // outputs
  output logic o_timeout_alert_out,
  output logic o_module_restart,
  output logic [1:0] o_stage,
  output logic o_expired
);

  dsw_pkg::dsw_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [3:0] alert_cnt_q, alert_cnt_d;
  logic [3:0] rst_cnt_q, rst_cnt_d;
  logic alert_q, alert_d;
  logic restart_q, restart_d;
  logic expired_q, expired_d;

  // effective action of a code in a stage; bad codes and stage-two delay become no action
  function automatic logic [3:0] eff_code(input logic [3:0] code, input logic first);
    unique case (code)
      dsw_pkg::ACT_RESET, dsw_pkg::ACT_ALERT, dsw_pkg::ACT_RESET_ALERT,
      dsw_pkg::ACT_DELAY_ALERT: eff_code = code; // see RULE11
      dsw_pkg::ACT_DELAY: eff_code = first ? code : dsw_pkg::ACT_NONE; // see RULE4
      default: eff_code = dsw_pkg::ACT_NONE;
    endcase
  endfunction

  function automatic logic does_reset(input logic [3:0] code);
    does_reset = (code == dsw_pkg::ACT_RESET) || (code == dsw_pkg::ACT_RESET_ALERT);
  endfunction

  function automatic logic does_alert(input logic [3:0] code);
    does_alert = code[3]; // see RULE5 see RULE6
  endfunction

  logic [3:0] c1, c2, cur;
  logic fire;
  assign c1 = eff_code(i_stage1_code, 1'b1);
  assign c2 = eff_code(i_stage2_code, 1'b0);
  assign cur = (state_q == dsw_pkg::DSW_STAGE1) ? c1 : c2;
  assign fire = (cnt_q == '0) &&
                ((state_q == dsw_pkg::DSW_STAGE1) || (state_q == dsw_pkg::DSW_STAGE2));

  // stage sequencing and countdown
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    expired_d = expired_q;
    if (!i_enable) begin
      state_d = dsw_pkg::DSW_IDLE;
      expired_d = 1'b0;
    end else if (i_service || state_q == dsw_pkg::DSW_IDLE) begin
      state_d = dsw_pkg::DSW_STAGE1; // see RULE10
      cnt_d = i_stage1_ticks; // see RULE11
      expired_d = 1'b0;
    end else if (state_q == dsw_pkg::DSW_STAGE1 || state_q == dsw_pkg::DSW_STAGE2) begin
      if (state_q == dsw_pkg::DSW_STAGE1 && i_stage1_code == dsw_pkg::ACT_NONE) begin
        // disabled first stage passes straight over to stage two
        state_d = dsw_pkg::DSW_STAGE2; // see RULE2
        cnt_d = i_stage2_ticks;
      end else if (state_q == dsw_pkg::DSW_STAGE2 && i_stage2_code == dsw_pkg::ACT_NONE) begin
        // only an all-zero code skips; other dead codes still count and expire quietly
        state_d = dsw_pkg::DSW_DONE; // see RULE2
      end else if (cnt_q != '0) begin
        cnt_d = cnt_q - 1'b1;
      end else if (state_q == dsw_pkg::DSW_STAGE1) begin
        state_d = dsw_pkg::DSW_STAGE2; // see RULE1
        cnt_d = i_stage2_ticks;
        expired_d = 1'b1;
      end else begin
        state_d = dsw_pkg::DSW_DONE; // wait in DONE until the next service or until the guard is disabled
        expired_d = 1'b1;
      end
    end
  end

  // action pulses; an action in a skipped stage never fires since the action gate also needs a live code in cur
  always_comb begin
    alert_d = 1'b0;
    restart_d = 1'b0;
    alert_cnt_d = alert_cnt_q;
    rst_cnt_d = rst_cnt_q;
    if (alert_cnt_q != 4'h0) begin
      alert_cnt_d = alert_cnt_q - 4'h1;
      alert_d = 1'b1;
    end
    if (rst_cnt_q != 4'h0) begin
      rst_cnt_d = rst_cnt_q - 4'h1;
      restart_d = 1'b1;
    end
    if (fire && i_enable && !i_service && cur != dsw_pkg::ACT_NONE) begin
      // alert only follows the chosen stage
      if (does_alert(cur) && ((state_q == dsw_pkg::DSW_STAGE2) == i_alert_sel)) begin
        alert_d = 1'b1; // see RULE7 see RULE8
        alert_cnt_d = dsw_pkg::PULSE_LAST;
      end
      if (does_reset(cur)) begin
        restart_d = 1'b1; // see RULE3 see RULE9
        rst_cnt_d = dsw_pkg::PULSE_LAST;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= dsw_pkg::DSW_IDLE;
      cnt_q <= '0;
      alert_cnt_q <= 4'h0;
      rst_cnt_q <= 4'h0;
      alert_q <= 1'b0;
      restart_q <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      alert_cnt_q <= alert_cnt_d;
      rst_cnt_q <= rst_cnt_d;
      alert_q <= alert_d;
      restart_q <= restart_d;
      expired_q <= expired_d;
    end
  end

  assign o_timeout_alert_out = alert_q;
  assign o_module_restart = restart_q;
  assign o_stage = state_q;
  assign o_expired = expired_q;

  // checks
  property p_alert_len;
    @(posedge i_mclk) disable iff (!i_rst_b)
    $rose(alert_q) |-> alert_q [*4];
  endproperty
  a_alert_len: assert property (p_alert_len) else $error("alert pulse too short"); // see RULE7

  property p_reset_fire;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (fire && i_enable && !i_service && does_reset(cur)) |=> restart_q;
  endproperty
  a_reset_fire: assert property (p_reset_fire) else $error("no restart on expiry"); // see RULE3

  // restart pulse must stand its full length
  sequence s_restart_hold;
    restart_q [*4];
  endsequence

  property p_restart_len;
    @(posedge i_mclk) disable iff (!i_rst_b)
    $rose(restart_q) |-> s_restart_hold;
  endproperty
  a_restart_len: assert property (p_restart_len) else $error("restart pulse too short"); // see RULE3

  property p_expired;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (fire && i_enable && !i_service && cur != dsw_pkg::ACT_NONE) |=> expired_q;
  endproperty
  a_expired: assert property (p_expired) else $error("expiry not flagged"); // see RULE9

  property p_no_reset_alert_only;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (fire && cur == dsw_pkg::ACT_ALERT && rst_cnt_q == 4'h0) |=> !restart_q;
  endproperty
  a_no_reset_alert_only: assert property (p_no_reset_alert_only)
    else $error("restart on alert code"); // see RULE5

  property p_seq;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (fire && i_enable && !i_service && state_q == dsw_pkg::DSW_STAGE1)
      |=> state_q == dsw_pkg::DSW_STAGE2;
  endproperty
  a_seq: assert property (p_seq) else $error("stage two did not follow"); // see RULE1

  property p_service;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_enable && i_service) |=> (state_q == dsw_pkg::DSW_STAGE1 && cnt_q == $past(i_stage1_ticks));
  endproperty
  a_service: assert property (p_service) else $error("service did not restart"); // see RULE10

  property p_skip;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (state_q == dsw_pkg::DSW_STAGE1 && i_stage1_code == dsw_pkg::ACT_NONE && i_enable
      && !i_service)
      |=> state_q == dsw_pkg::DSW_STAGE2;
  endproperty
  a_skip: assert property (p_skip) else $error("disabled stage not skipped"); // see RULE2

  property p_delay2;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (fire && state_q == dsw_pkg::DSW_STAGE2 && i_stage2_code == dsw_pkg::ACT_DELAY
      && rst_cnt_q == 4'h0 && alert_cnt_q == 4'h0) |=> (!restart_q && !alert_q);
  endproperty
  a_delay2: assert property (p_delay2) else $error("delay acted in stage two"); // see RULE4

  property p_count;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (state_q == dsw_pkg::DSW_STAGE1 && c1 != dsw_pkg::ACT_NONE && cnt_q != '0
      && i_enable && !i_service) |=> cnt_q == $past(cnt_q) - 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("counter did not tick"); // see RULE11

endmodule
`default_nettype wire

//--- pkg/dsw_pkg.sv
package dsw_pkg;
  // stage action codes
  localparam logic [3:0] ACT_NONE = 4'h0;
  localparam logic [3:0] ACT_RESET = 4'h1;
  localparam logic [3:0] ACT_DELAY = 4'h5;
  localparam logic [3:0] ACT_ALERT = 4'h8;
  localparam logic [3:0] ACT_RESET_ALERT = 4'h9;
  localparam logic [3:0] ACT_DELAY_ALERT = 4'hD;
  // reset values
  localparam logic [1:0] RST_STAGE = 2'h0;
  // length of the alert and module restart pulses, in clock cycles
  localparam int PULSE_CYCLES = 4;
  localparam logic [3:0] PULSE_LAST = 4'(PULSE_CYCLES - 1);

  typedef enum logic [1:0] {
    DSW_IDLE,
    DSW_STAGE1,
    DSW_STAGE2,
    DSW_DONE
  } dsw_state_t;
endpackage

//--- test/dsw_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module dsw_host_model (
  // clock and controls from the bench
  input wire logic i_mclk,
  input wire logic i_kick_en,
  input wire logic i_clr,
  // carrier side
  input wire logic i_alert,
  // host side
  output logic o_service,
  output int o_alert_cnt
);
  int gap;
  // software kicks every third cycle, well inside any stage time used
  initial begin
    o_service = 1'b0;
    gap = 0;
    forever begin
      @(negedge i_mclk);
      gap = (gap + 1) % 3;
      o_service = i_kick_en && (gap == 0);
    end
  end
  // carrier logic counts cycles with the alert line high
  always @(posedge i_mclk) begin
    if (i_clr) o_alert_cnt <= 0;
    else if (i_alert === 1'b1) o_alert_cnt <= o_alert_cnt + 1;
  end
endmodule
`default_nettype wire

//--- test/dual_stage_watchdog_test.sv
`timescale 1ns/10ps
`default_nettype none
module dual_stage_watchdog_test;
  logic i_mclk, i_rst_b, i_enable, i_alert_sel, i_service, kick, clr, o_alert, o_rst, o_exp;
  logic [3:0] c1, c2;
  logic [31:0] t1, t2;
  logic [1:0] o_stage;
  int alert_cnt, error_cnt, total_checks, rst_cnt, saw2, exp_seen;
  dsw_two_stage_guard_timer #(.CNT_W(32)) u_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_enable(i_enable), .i_stage1_code(c1), .i_stage2_code(c2), .i_stage1_ticks(t1),
    .i_stage2_ticks(t2), .i_alert_sel(i_alert_sel), .i_service(i_service),
    .o_timeout_alert_out(o_alert), .o_module_restart(o_rst), .o_stage(o_stage),
    .o_expired(o_exp));
  dsw_host_model u_host (.i_mclk(i_mclk), .i_kick_en(kick), .i_clr(clr), .i_alert(o_alert),
    .o_service(i_service), .o_alert_cnt(alert_cnt));
  // 10 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // fixed window keeps a hung guard from stalling the run
  task automatic run(input int n);
    rst_cnt = 0;
    saw2 = 0;
    exp_seen = 0;
    @(negedge i_mclk) clr = 1'b1;
    @(negedge i_mclk) begin clr = 1'b0; i_enable = 1'b1; end
    repeat (n) begin
      @(posedge i_mclk);
      #1;
      rst_cnt += (o_rst === 1'b1);
      saw2 |= (o_stage === 2'h2);
      exp_seen |= (o_exp === 1'b1);
    end
    @(negedge i_mclk) i_enable = 1'b0;
    @(negedge i_mclk);
  endtask
  function automatic int is_r(input logic [3:0] c);
    return int'(c == dsw_pkg::ACT_RESET || c == dsw_pkg::ACT_RESET_ALERT);
  endfunction
  function automatic int is_a(input logic [3:0] c);
    return int'(c == dsw_pkg::ACT_ALERT || c == dsw_pkg::ACT_RESET_ALERT ||
      c == dsw_pkg::ACT_DELAY_ALERT);
  endfunction
  // every code, stage two delay refused, alert routing both ways
  task automatic code_table();
    logic [11:0] rows [11] = '{12'h000, 12'h100, 12'h500, 12'h800, 12'h900, 12'hD00,
      12'h300, 12'h051, 12'h891, 12'h081, 12'hD80};
    foreach (rows[k]) begin
      {c1, c2} = rows[k][11:4];
      i_alert_sel = rows[k][0];
      run(24);
      chk(8'(rst_cnt), 8'(dsw_pkg::PULSE_CYCLES * (is_r(c1) + is_r(c2))));
      chk(8'(alert_cnt), 8'(dsw_pkg::PULSE_CYCLES * is_a(i_alert_sel ? c2 : c1)));
      if (c2 != 4'h0) chk(8'(saw2), 8'h01);
    end
  endtask
  // kicks hold off the restart; once they stop the restart comes
  task automatic service_test();
    {c1, c2, t1, i_alert_sel} = {dsw_pkg::ACT_RESET, dsw_pkg::ACT_NONE, 32'h5, 1'b0};
    kick = 1'b1;
    run(30);
    chk(8'(rst_cnt + saw2), 8'h00);
    chk(8'(exp_seen), 8'h00);
    kick = 1'b0;
    run(20);
    chk(8'(rst_cnt), 8'(dsw_pkg::PULSE_CYCLES));
    chk(8'(exp_seen), 8'h01);
  endtask
  initial begin
    {i_rst_b, i_enable, i_alert_sel, kick, clr, c1, c2} = '0;
    {t1, t2, error_cnt, total_checks} = {32'h3, 32'h3, 32'h0, 32'h0};
    repeat (5) @(negedge i_mclk);
    i_rst_b = 1'b1;
    chk({3'h0, o_alert, o_rst, o_exp, o_stage}, 8'h00);
    code_table();
    service_test();
    stop_test();
  end
endmodule
`default_nettype wire
